// ==== rtl/pdld_lock_detect.v ====
// Digital lock detector with serial register port and shared lock pin
// Operation
// - Window type bit picks digital or analog window
// - Duration code sets half to 64 timer cycles
// - Speed code sets timer clock, 00 fastest
// - Timer clock observable on the shared pin
// - Threshold code sets consecutive good pairs needed
// - Enable bit, reset one, gates lock detection
// - Lock flag readable at status bit one
// - Select code one drives lock onto pin
// - Pin carries read data during serial reads
// - Digital window spans 8 to 4096 ns at 125 MHz
// - Edge arrival difference measured, either order
`timescale 1ns/100ps
`include "pdld_map.vh"

module pdld_lock_detect (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire serialEnable,
  input  wire serialClock,
  input  wire serialDataIn,
  input  wire refEdgeIn,
  input  wire vcoDivEdgeIn,
  output reg  lockOrSerialOutPin,
  output reg  lockDetected
);

  // --------------------------------------------------------------------
  // Input synchronisers and edge detection
  // --------------------------------------------------------------------
  reg  [4:0] syncA;
  reg  [4:0] syncB;
  reg  [4:0] syncD;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
      syncD <= 5'h00;
    end else begin
      syncA <= {vcoDivEdgeIn, refEdgeIn, serialDataIn, serialClock, serialEnable};
      syncB <= syncA;
      syncD <= syncB;
    end
  end

  wire       senS    = syncB[0];
  wire       sckRise = syncB[1] & ~syncD[1];
  wire       sckFall = ~syncB[1] & syncD[1];
  wire       sdiS    = syncB[2];
  wire       refE    = syncB[3] & ~syncD[3];
  wire       vcoE    = syncB[4] & ~syncD[4];

  // --------------------------------------------------------------------
  // Serial register port
  // --------------------------------------------------------------------
  reg  [23:0] ctrl;
  reg  [4:0]  gpoSel;
  reg         sdoOff;
  reg  [23:0] inShift;
  reg  [23:0] readShift;
  reg  [4:0]  bitCnt;
  reg  [5:0]  addr;
  reg         rdFrame;
  reg         readActive;
  reg  [23:0] readData;
  wire [5:0]  addrNow = {inShift[4:0], sdiS};

  always @* begin
    case (addrNow)
      `PDLD_ADDR_CTRL: readData = ctrl;
      `PDLD_ADDR_GPO:  readData = {17'h00000, sdoOff, 1'b0, gpoSel};
      `PDLD_ADDR_STAT: readData = {22'h000000, lockDetected, 1'b0};
      default:         readData = 24'h000000;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= `PDLD_CTRL_RST;
      gpoSel     <= `PDLD_GPO_SEL_RST;
      sdoOff     <= 1'b0;
      inShift    <= 24'h000000;
      readShift  <= 24'h000000;
      bitCnt     <= 5'h00;
      addr       <= 6'h00;
      rdFrame    <= 1'b0;
      readActive <= 1'b0;
    end else if (!senS) begin
      bitCnt     <= 5'h00;
      rdFrame    <= 1'b0;
      readActive <= 1'b0;
    end else if (sckRise) begin
      inShift <= {inShift[22:0], sdiS};
      if (bitCnt != 5'h1f)
        bitCnt <= bitCnt + 5'h01;
      if (bitCnt == 5'h00)
        rdFrame <= sdiS;
      if (bitCnt == `PDLD_ADDR_LAST_BIT) begin
        addr <= addrNow;
        if (rdFrame) begin
          readActive <= 1'b1;
          readShift  <= readData;
        end
      end
      if (bitCnt == `PDLD_FRAME_LAST_BIT && !rdFrame) begin
        if (addr == `PDLD_ADDR_CTRL)
          ctrl <= {inShift[22:0], sdiS};
        if (addr == `PDLD_ADDR_GPO) begin
          gpoSel <= {inShift[3:0], sdiS};
          sdoOff <= inShift[5];
        end
      end
    end else if (sckFall && readActive) begin
      readShift <= {readShift[22:0], 1'b0};
    end
  end

  // --------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------
  wire [2:0] thrCode = ctrl[`PDLD_THR_LSB +: 3];
  wire       ldEnable = ctrl[`PDLD_EN_BIT];
  wire       digital  = ctrl[`PDLD_WTYPE_BIT];
  wire [2:0] durCode  = ctrl[`PDLD_DUR_LSB +: 3];
  wire [1:0] spdCode  = ctrl[`PDLD_SPD_LSB +: 2];
  wire [8:0] cfgKey   = {spdCode, durCode, digital, thrCode};
  reg  [8:0] cfgPrev;
  wire       cfgChange = cfgKey != cfgPrev;

  reg  [15:0] threshold;
  always @* begin
    case (thrCode)
      3'h0:    threshold = `PDLD_THR0;
      3'h1:    threshold = `PDLD_THR1;
      3'h2:    threshold = `PDLD_THR2;
      3'h3:    threshold = `PDLD_THR3;
      3'h4:    threshold = `PDLD_THR4;
      3'h5:    threshold = `PDLD_THR5;
      3'h6:    threshold = `PDLD_THR6;
      default: threshold = `PDLD_THR7;
    endcase
  end

  // --------------------------------------------------------------------
  // Window timer
  // --------------------------------------------------------------------
  wire timerClk;
  wire halfTick;
  reg  timerRestart;

  pdld_window_timer uTimer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .speed    (spdCode),
    .restart  (timerRestart),
    .timerClk (timerClk),
    .halfTick (halfTick)
  );

  // Window in half timer cycles when digital, system cycles when analog
  // window source select
  wire [31:0] analogWin = `PDLD_ANALOG_WIN_CYC;
  wire [7:0] winLen   = digital ? (8'h01 << durCode) : analogWin[7:0];
  wire       unitTick = digital ? halfTick : 1'b1;

  // --------------------------------------------------------------------
  // Edge pair measurement
  // --------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_MISS = 2'h2;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg        pendRef;
  reg        next_pendRef;
  reg  [7:0] elapsed;
  reg        goodPair;
  reg        badPair;
  wire       otherE = pendRef ? vcoE : refE;
  wire       sameE  = pendRef ? refE : vcoE;

  always @* begin
    next_state   = state;
    next_pendRef = pendRef;
    goodPair     = 1'b0;
    badPair      = 1'b0;
    timerRestart = 1'b0;
    case (state)
      ST_IDLE: begin
        if (refE && vcoE) begin
          goodPair = 1'b1;
        end else if (refE || vcoE) begin
          next_state   = ST_WAIT;
          next_pendRef = refE;
          timerRestart = 1'b1;
        end
      end
      ST_WAIT: begin
        if (otherE) begin
          goodPair   = elapsed < winLen;
          badPair    = ~(elapsed < winLen);
          next_state = ST_IDLE;
        end else if (sameE) begin
          badPair      = 1'b1;
          timerRestart = 1'b1;
        end else if (elapsed >= winLen) begin
          badPair    = 1'b1;
          next_state = ST_MISS;
        end
      end
      ST_MISS: begin
        if (otherE) begin
          next_state = ST_IDLE;
        end else if (sameE) begin
          next_state   = ST_WAIT;
          timerRestart = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // Lock qualification
  // --------------------------------------------------------------------
  reg  [15:0] goodCnt;
  wire [15:0] next_goodCnt = goodCnt + 16'h0001;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      pendRef      <= 1'b0;
      elapsed      <= 8'h00;
      goodCnt      <= 16'h0000;
      lockDetected <= 1'b0;
      cfgPrev      <= 9'h000;
    end else begin
      cfgPrev <= cfgKey;
      if (!ldEnable || cfgChange) begin
        state        <= ST_IDLE;
        elapsed      <= 8'h00;
        goodCnt      <= 16'h0000;
        lockDetected <= 1'b0;
      end else begin
        state   <= next_state;
        pendRef <= next_pendRef;
        if (timerRestart)
          elapsed <= 8'h00;
        else if (state == ST_WAIT && unitTick && elapsed != 8'hff)
          elapsed <= elapsed + 8'h01;
        if (badPair) begin
          goodCnt      <= 16'h0000;
          lockDetected <= 1'b0;
        end else if (goodPair) begin
          if (goodCnt != threshold)
            goodCnt <= next_goodCnt;
          if (next_goodCnt >= threshold)
            lockDetected <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Shared lock and serial out pin
  // --------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lockOrSerialOutPin <= 1'b0;
    end else if (readActive && !sdoOff) begin
      lockOrSerialOutPin <= readShift[23];
    end else if (gpoSel == `PDLD_GPO_SEL_LOCK) begin
      lockOrSerialOutPin <= lockDetected;
    end else if (gpoSel == `PDLD_GPO_SEL_TIMER) begin
      lockOrSerialOutPin <= timerClk;
    end else begin
      lockOrSerialOutPin <= 1'b0;
    end
  end

endmodule // pdld_lock_detect

// ==== rtl/pdld_map.vh ====
// Register map, field positions and timing constants of the lock detector
`ifndef PDLD_MAP_VH
`define PDLD_MAP_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PDLD_ADDR_CTRL      6'h07
`define PDLD_ADDR_GPO       6'h0f
`define PDLD_ADDR_STAT      6'h12

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define PDLD_CTRL_RST       24'h00014d
`define PDLD_THR_LSB        0
`define PDLD_EN_BIT         3
`define PDLD_WTYPE_BIT      6
`define PDLD_DUR_LSB        7
`define PDLD_SPD_LSB        10

// ----------------------------------------------------------------------
// Output select and status register fields
// ----------------------------------------------------------------------
`define PDLD_GPO_SEL_RST    5'h01
`define PDLD_GPO_SEL_LOCK   5'h01
`define PDLD_GPO_SEL_TIMER  5'h02
`define PDLD_GPO_SDO_OFF    6
`define PDLD_STAT_LOCK_BIT  1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PDLD_CLK_MHZ        125
`define PDLD_ANALOG_WIN_NS  10
`define PDLD_ANALOG_WIN_CYC ((`PDLD_ANALOG_WIN_NS * `PDLD_CLK_MHZ + 999) / 1000)
`define PDLD_TMR_HALF0      3'h1
`define PDLD_TMR_HALF1      3'h2
`define PDLD_TMR_HALF2      3'h3
`define PDLD_TMR_HALF3      3'h4

// ----------------------------------------------------------------------
// Lock thresholds and serial frame
// ----------------------------------------------------------------------
`define PDLD_THR0           16'h0005
`define PDLD_THR1           16'h0020
`define PDLD_THR2           16'h0060
`define PDLD_THR3           16'h0100
`define PDLD_THR4           16'h0200
`define PDLD_THR5           16'h0800
`define PDLD_THR6           16'h2000
`define PDLD_THR7           16'hffff
`define PDLD_ADDR_LAST_BIT  5'h06
`define PDLD_FRAME_LAST_BIT 5'h1e

`endif

// ==== rtl/pdld_window_timer.v ====
// Lock window timer clock, stands in for the internal ring oscillator
`timescale 1ns/100ps
`include "pdld_map.vh"

module pdld_window_timer (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire [1:0] speed,
  input  wire       restart,
  output reg        timerClk,
  output reg        halfTick
);

  reg  [2:0] cnt;
  reg  [2:0] halfPeriod;

  always @* begin
    case (speed)
      2'h0:    halfPeriod = `PDLD_TMR_HALF0;
      2'h1:    halfPeriod = `PDLD_TMR_HALF1;
      2'h2:    halfPeriod = `PDLD_TMR_HALF2;
      default: halfPeriod = `PDLD_TMR_HALF3;
    endcase
  end

  // Restart aligns the timer phase to the first edge of a pair
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 3'h0;
      timerClk <= 1'b0;
      halfTick <= 1'b0;
    end else if (restart) begin
      cnt      <= 3'h0;
      timerClk <= 1'b0;
      halfTick <= 1'b0;
    end else if (cnt == halfPeriod - 3'h1) begin
      cnt      <= 3'h0;
      timerClk <= ~timerClk;
      halfTick <= 1'b1;
    end else begin
      cnt      <= cnt + 3'h1;
      halfTick <= 1'b0;
    end
  end

endmodule // pdld_window_timer

// ==== tb/pdld_host_model.sv ====
// Host controller model driving serial frames
`timescale 1ns/100ps
module pdld_host_model (
  input  wire logic clk_sys,
  input  wire logic lockOrSerialOutPin,
  output var  logic serialEnable,
  output var  logic serialClock,
  output var  logic serialDataIn
);
  initial {serialEnable, serialClock, serialDataIn} = 3'h0;
  // Serial clock idles low; 160 ns period
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q);
    logic [30:0] f;
    f = {rw, a, d};
    q = 24'h0;
    @(negedge clk_sys);
    serialEnable = 1'b1;
    for (int i = 30; i >= 0; i--) begin
      serialDataIn = f[i];
      repeat (10) @(negedge clk_sys);
      serialClock = 1'b1;
      repeat (10) @(negedge clk_sys);
      // Read bit stands until the falling edge, so take it just before
      if (i > 0 && i <= 24) q = {q[22:0], lockOrSerialOutPin};
      serialClock = 1'b0;
    end
    // Released line flips so a stale bit is never mistaken for data
    serialDataIn = ~serialDataIn;
    serialEnable = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule // pdld_host_model

// ==== tb/pdld_lock_detect_props.sv ====
// Port checker for the lock detector
`timescale 1ns/100ps
module pdld_lock_detect_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serialEnable,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic refEdgeIn,
  input wire logic vcoDivEdgeIn,
  input wire logic lockOrSerialOutPin,
  input wire logic lockDetected
);
  // ----
  // Edge ages, pair and frame counts
  // ----
  logic [9:0] refAge, vcoAge, quiet;
  logic [7:0] vcoCnt;
  logic [5:0] rises;
  logic       refQ, vcoQ, sclkQ;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {refAge, vcoAge} <= '1;
      {quiet, vcoCnt, rises, refQ, vcoQ, sclkQ} <= '0;
    end else begin
      {refQ, vcoQ, sclkQ} <= {refEdgeIn, vcoDivEdgeIn, serialClock};
      refAge <= refEdgeIn && !refQ ? 10'h0 : refAge + 10'(~&refAge);
      vcoAge <= vcoDivEdgeIn && !vcoQ ? 10'h0 : vcoAge + 10'(~&vcoAge);
      quiet <= refEdgeIn ^ refQ || vcoDivEdgeIn ^ vcoQ || serialEnable ? 10'h0
             : quiet + 10'(~&quiet);
      vcoCnt <= lockDetected ? 8'h0 : vcoCnt + 8'(vcoDivEdgeIn && !vcoQ && ~&vcoCnt);
      rises <= !serialEnable ? 6'h0 : rises + 6'(serialClock && !sclkQ);
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_reset_clear: assert property ($rose(rst_n) |-> !lockDetected && !lockOrSerialOutPin)
    else $error("outputs set after reset");
  a_lock_recent_edge: assert property ($rose(lockDetected) |-> refAge < 12 || vcoAge < 12)
    else $error("lock rose without a recent edge");
  a_both_edges_seen: assert property ($rose(lockDetected) |-> refAge < 600 && vcoAge < 600)
    else $error("lock rose without both edges");
  a_min_pairs: assert property ($rose(lockDetected) |-> vcoCnt >= 8'h05)
    else $error("lock rose before five pairs");
  a_pin_shows_lock: assert property ($rose(lockDetected) && !serialEnable
      && !$past(serialEnable, 4) |=> lockOrSerialOutPin)
    else $error("pin missed lock rise");
  a_pin_drops_lock: assert property ($fell(lockDetected) && !serialEnable
      && !$past(serialEnable, 4) |=> !lockOrSerialOutPin)
    else $error("pin missed lock fall");
  a_fall_has_cause: assert property ($fell(lockDetected) |-> quiet < 600)
    else $error("lock fell with no edge or frame");
  a_bit_steady: assert property (serialEnable && rises < 6'h1f && serialClock
      && $past(serialClock, 7) && $past(lockDetected) == $past(lockDetected, 2)
      |-> $stable(lockOrSerialOutPin))
    else $error("pin moved while serial clock high");
endmodule // pdld_lock_detect_props

bind pdld_lock_detect pdld_lock_detect_props i_pdld_lock_detect_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .serialEnable(serialEnable),
  .serialClock(serialClock), .serialDataIn(serialDataIn), .refEdgeIn(refEdgeIn),
  .vcoDivEdgeIn(vcoDivEdgeIn), .lockOrSerialOutPin(lockOrSerialOutPin),
  .lockDetected(lockDetected));

// ==== tb/pdld_lock_detect_test.sv ====
// Self-checking bench for the lock detector
`timescale 1ns/100ps
`include "pdld_map.vh"
module pdld_lock_detect_test;
  logic        clk_sys = 0, rst_n = 0, refEdgeIn = 0, vcoDivEdgeIn = 0, p;
  wire         serialEnable, serialClock, serialDataIn, lockOrSerialOutPin, lockDetected;
  int          failures = 0, comparisons = 0, cycles = 0, tog, s, d, w;
  int          cnt[3] = '{5, 32, 96};
  logic [23:0] rd;
  initial forever #4 clk_sys = ~clk_sys;
  pdld_host_model i_pdld_host_model (.clk_sys(clk_sys), .lockOrSerialOutPin(lockOrSerialOutPin),
    .serialEnable(serialEnable), .serialClock(serialClock), .serialDataIn(serialDataIn));
  pdld_lock_detect i_pdld_lock_detect (.clk_sys(clk_sys), .rst_n(rst_n),
    .serialEnable(serialEnable), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .refEdgeIn(refEdgeIn), .vcoDivEdgeIn(vcoDivEdgeIn),
    .lockOrSerialOutPin(lockOrSerialOutPin), .lockDetected(lockDetected));
  // ----
  // Access and checking tasks
  // ----
  task check(input string n, input logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task conclude;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [5:0] a, input logic [23:0] v);
    i_pdld_host_model.xfer(1'b0, a, v, rd);
  endtask
  task rdchk(input string n, input logic [5:0] a, input logic [23:0] e);
    i_pdld_host_model.xfer(1'b1, a, 24'h0, rd);
    check(n, rd, e);
  endtask
  task pair(input int r, v);
    for (int t = 0; t < 80; t++) begin
      @(negedge clk_sys);
      refEdgeIn = t >= r && t < r + 30;
      vcoDivEdgeIn = t >= v && t < v + 30;
    end
  endtask
  // Pairs alternate order; last good pair must lock, one late pair unlocks
  task qualify(input logic [23:0] cfg, input int n, g, b);
    wr(6'h07, cfg);
    for (int i = 1; i < n; i++) pair(i % 2 ? 0 : g, i % 2 ? g : 0);
    check("lock early", lockDetected, 1'b0);
    pair(0, g);
    check("lock", lockDetected, 1'b1);
    check("pin lock", lockOrSerialOutPin, 1'b1);
    pair(b, 0);
    check("lock after late pair", lockDetected, 1'b0);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rdchk("ctrl reset", 6'h07, 24'h00014d);
    rdchk("select reset", 6'h0f, 24'h000001);
    rdchk("status reset", 6'h12, 24'h000000);
    wr(6'h3f, 24'hffffff);
    rdchk("unmapped", 6'h3f, 24'h000000);
    qualify(24'h000148, 5, 3, 6);
    qualify(24'h000108, 5, 1, 3);
    for (int i = 0; i < 10; i++) begin
      s = i < 4 ? i : 0;
      d = i < 4 ? 3 : i - 4;
      w = (2 ** d) * (s + 1);
      qualify({12'h0, s[1:0], d[2:0], 7'h48}, 5, w / 4, w + 2);
    end
    for (int k = 0; k < 3; k++) qualify({21'h29, k[2:0]}, cnt[k], 0, 10);
    wr(6'h07, 24'h000148);
    repeat (5) pair(0, 0);
    rdchk("status locked", 6'h12, 24'h000002);
    check("pin after read", lockOrSerialOutPin, 1'b1);
    wr(6'h0f, 24'h000041);
    rdchk("read with pin held", 6'h0f, 24'hffffff);
    wr(6'h0f, 24'h000001);
    wr(6'h12, 24'h000000);
    wr(6'h07, 24'h000148);
    check("lock same cfg", lockDetected, 1'b1);
    rdchk("ctrl rw", 6'h07, 24'h000148);
    wr(6'h07, 24'h000149);
    check("lock cfg change", lockDetected, 1'b0);
    wr(6'h07, 24'h000140);
    repeat (6) pair(0, 0);
    check("lock disabled", lockDetected, 1'b0);
    wr(6'h07, 24'h000d48);
    wr(6'h0f, 24'h000002);
    tog = 0;
    p = lockOrSerialOutPin;
    repeat (48) begin
      @(negedge clk_sys);
      tog += p != lockOrSerialOutPin;
      p = lockOrSerialOutPin;
    end
    check("timer toggles", tog, 48 / `PDLD_TMR_HALF3);
    rst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("pin after reset", lockOrSerialOutPin, 1'b0);
    rdchk("ctrl reset again", 6'h07, 24'h00014d);
    conclude();
  end
endmodule // pdld_lock_detect_test
